// ---- core/tx_ring_regs.svh ----
// register offsets, descriptor field positions and reset values
// assumes inclusion by bare name from the ring engine and the bench
`ifndef TX_RING_REGS_SVH
`define TX_RING_REGS_SVH

// register port offsets
`define REG_CTRL 8'h00
`define REG_BASE_LO 8'h04
`define REG_BASE_HI 8'h08
`define REG_STATUS 8'h0C
`define REG_LAST_ERR 8'h10

// control register bits
`define CTRL_TXON 0
`define CTRL_INIT 1
`define CTRL_ONE_TRY 2

// status word (word 1) bits
`define W1_OWN 15
`define W1_ERR 14
`define W1_RESV 13
`define W1_FIRST 9
`define W1_LAST 8

// error word (word 3) bits
`define W3_BUF_ERR 15
`define W3_UNDER 14
`define W3_RESV 13
`define W3_LATE 12
`define W3_CARRIER 11
`define W3_RETRY 10

// descriptor word byte offsets inside an eight-byte descriptor
`define DW_ADDR 24'h00_0000
`define DW_STAT 24'h00_0002
`define DW_SIZE 24'h00_0004
`define DW_ERR 24'h00_0006

// reset values
`define BASE_RST 24'h00_0000
`define LOG2_RST 3'h0

`endif

// ---- core/tx_ring_pkg.sv ----
// types shared by the transmit descriptor ring engine
// assumes nothing beyond a SystemVerilog compiler
package tx_ring_pkg;

    // one-hot engine states
    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_POLL = 10'h002,
        S_RD_ADDR = 10'h004,
        S_RD_SIZE = 10'h008,
        S_LK_STAT = 10'h010,
        S_LK_ADDR = 10'h020,
        S_LK_SIZE = 10'h040,
        S_XMIT = 10'h080,
        S_WR_ERR = 10'h100,
        S_WR_STAT = 10'h200
    } fsm_t;

    // one word access to the shared buffer memory
    typedef struct packed {
        logic req;
        logic we;
        logic [23:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    // whole state of the engine
    typedef struct packed {
        fsm_t st;
        logic [7:0] ptr;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] w2;
        logic [15:0] n0;
        logic [15:0] n1;
        logic [15:0] n2;
        logic nxt_ok;
        logic chain;
        logic buf_done;
        logic buf_valid;
        logic buf_err;
        logic und_err;
        logic late_col;
        logic car_lost;
        logic rty_out;
        logic [4:0] tries;
        logic [9:0] col_cnt;
        logic col_run;
        logic abort;
        logic tx_on;
        logic one_try;
        logic [23:0] base;
        logic [2:0] ring_log2;
        logic [15:0] rdata;
        logic [15:0] last_err;
    } state_t;

endpackage : tx_ring_pkg

// ---- core/tx_desc_ring_engine.sv ----
// transmit descriptor ring engine: polls, prefetches, chains and returns descriptors
// assumes a one-word memory port with ack, and a transmitter that reports its events
`timescale 1ns/10ps
`include "tx_ring_regs.svh"

module tx_desc_ring_engine #(
    parameter logic [4:0] RETRIES = 5'h10
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // shared buffer memory
    output tx_ring_pkg::mem_req_t mem,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // buffer hand-off to the data fetcher
    output logic buf_valid,
    output logic [23:0] buf_addr,
    output logic [11:0] buf_len,
    output logic buf_last,
    input wire logic buf_done,
    // transmitter events
    input wire logic tx_attempt_start,
    input wire logic tx_sending,
    input wire logic carrier_present,
    input wire logic tx_collision,
    input wire logic tx_late_collision,
    input wire logic fifo_empty,
    input wire logic tx_complete,
    output logic tx_abort,
    // receive ring guard
    input wire logic rx_desc_owned,
    output logic rx_accept
);

    tx_ring_pkg::state_t s;
    tx_ring_pkg::state_t next_s;
    logic [7:0] ptr_mask;
    logic [7:0] ptr_next;
    logic txing;
    logic err_any;
    logic [4:0] limit;
    logic [15:0] err_word;

    // descriptor byte address for a ring index and word offset
    function automatic logic [23:0] desc_addr(input logic [23:0] base, input logic [7:0] idx,
                                              input logic [23:0] word);
        desc_addr = 24'(base + {13'h0000, idx, 3'h0} + word);
    endfunction : desc_addr

    // ring wrap and shared status terms
    assign ptr_mask = 8'(({1'b0, 8'h01} << s.ring_log2) - 9'h001);
    assign ptr_next = 8'(s.ptr + 8'h01) & ptr_mask;
    assign txing = (s.st == tx_ring_pkg::S_LK_STAT) || (s.st == tx_ring_pkg::S_LK_ADDR) ||
                   (s.st == tx_ring_pkg::S_LK_SIZE) || (s.st == tx_ring_pkg::S_XMIT);
    assign err_any = s.late_col | s.car_lost | s.und_err | s.rty_out;
    assign limit = s.one_try ? 5'h01 : RETRIES;
    assign err_word = {s.buf_err, s.und_err, 1'b0, s.late_col, s.car_lost, s.rty_out, s.col_cnt};

    // memory access follows the registered state
    always_comb begin
        mem.req = 1'b1;
        mem.we = 1'b0;
        mem.wdata = 16'h0000;
        mem.addr = desc_addr(s.base, s.ptr, `DW_STAT);
        unique case (s.st)
            tx_ring_pkg::S_POLL: mem.addr = desc_addr(s.base, s.ptr, `DW_STAT);
            tx_ring_pkg::S_RD_ADDR: mem.addr = desc_addr(s.base, s.ptr, `DW_ADDR);
            tx_ring_pkg::S_RD_SIZE: mem.addr = desc_addr(s.base, s.ptr, `DW_SIZE);
            tx_ring_pkg::S_LK_STAT: mem.addr = desc_addr(s.base, ptr_next, `DW_STAT);
            tx_ring_pkg::S_LK_ADDR: mem.addr = desc_addr(s.base, ptr_next, `DW_ADDR);
            tx_ring_pkg::S_LK_SIZE: mem.addr = desc_addr(s.base, ptr_next, `DW_SIZE);
            tx_ring_pkg::S_WR_ERR: begin
                mem.we = 1'b1;
                mem.addr = desc_addr(s.base, s.ptr, `DW_ERR);
                mem.wdata = err_word;
            end
            tx_ring_pkg::S_WR_STAT: begin
                // ownership cleared in the same word as the summary
                mem.we = 1'b1;
                mem.wdata = {1'b0, err_any, 1'b0, s.w1[12:0]};
            end
            tx_ring_pkg::S_IDLE, tx_ring_pkg::S_XMIT: mem.req = 1'b0;
        endcase
    end

    // next state of the engine
    always_comb begin
        next_s = s;
        next_s.abort = 1'b0;
        next_s.buf_valid = 1'b0;
        next_s.rdata = 16'h0000;
        // register reads answer one cycle later
        if (reg_rd) begin
            unique case (reg_addr)
                `REG_CTRL: next_s.rdata = {13'h0000, s.one_try, 1'b0, s.tx_on};
                `REG_BASE_LO: next_s.rdata = s.base[15:0];
                `REG_BASE_HI: next_s.rdata = {5'h00, s.ring_log2, s.base[23:16]};
                `REG_STATUS: next_s.rdata = {s.ptr, 7'h00, (s.st != tx_ring_pkg::S_IDLE)};
                `REG_LAST_ERR: next_s.rdata = s.last_err;
                default: next_s.rdata = 16'h0000;
            endcase
        end
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `REG_CTRL: begin
                    next_s.tx_on = reg_wdata[`CTRL_TXON];
                    next_s.one_try = reg_wdata[`CTRL_ONE_TRY];
                    if (reg_wdata[`CTRL_INIT] && (s.st == tx_ring_pkg::S_IDLE)) begin
                        next_s.ptr = 8'h00;
                    end
                end
                `REG_BASE_LO: next_s.base[15:0] = reg_wdata;
                `REG_BASE_HI: begin
                    next_s.base[23:16] = reg_wdata[7:0];
                    next_s.ring_log2 = reg_wdata[10:8];
                end
                default: begin
                end
            endcase
        end
        // transmitter events while a packet is in flight
        if (txing) begin
            if (buf_done) begin
                next_s.buf_done = 1'b1;
            end
            if (tx_attempt_start) begin
                next_s.col_cnt = 10'h000;
                next_s.col_run = 1'b1;
            end else if (s.col_run) begin
                next_s.col_cnt = 10'(s.col_cnt + 10'h001);
            end
            if (tx_late_collision) begin
                next_s.late_col = 1'b1;
                next_s.abort = 1'b1;
                next_s.col_run = 1'b0;
            end else if (tx_collision) begin
                next_s.col_run = 1'b0;
                next_s.tries = 5'(s.tries + 5'h01);
                if (5'(s.tries + 5'h01) >= limit) begin
                    next_s.rty_out = 1'b1;
                    next_s.abort = 1'b1;
                end
            end
            if (tx_sending && !carrier_present) begin
                next_s.car_lost = 1'b1;
                next_s.abort = 1'b1;
            end
            if (fifo_empty && !s.buf_done && !buf_done) begin
                next_s.und_err = 1'b1;
                next_s.abort = 1'b1;
            end
        end
        // descriptor walk
        unique case (s.st)
            tx_ring_pkg::S_IDLE: begin
                if (s.tx_on) begin
                    next_s.st = tx_ring_pkg::S_POLL;
                end
            end
            tx_ring_pkg::S_POLL: begin
                if (mem_ack) begin
                    next_s.w1 = mem_rdata;
                    next_s.chain = 1'b0;
                    if (!mem_rdata[`W1_OWN]) begin
                        next_s.st = tx_ring_pkg::S_IDLE;
                    end else begin
                        {next_s.buf_err, next_s.und_err, next_s.late_col, next_s.car_lost, next_s.rty_out} = 5'h00;
                        next_s.tries = 5'h00;
                        next_s.col_cnt = 10'h000;
                        next_s.col_run = 1'b0;
                        // a stray buffer without a start flag goes back unsent, its summary clean
                        next_s.st = mem_rdata[`W1_FIRST] ? tx_ring_pkg::S_RD_ADDR : tx_ring_pkg::S_WR_STAT;
                    end
                end
            end
            tx_ring_pkg::S_RD_ADDR: begin
                if (mem_ack) begin
                    next_s.w0 = mem_rdata;
                    next_s.st = tx_ring_pkg::S_RD_SIZE;
                end
            end
            tx_ring_pkg::S_RD_SIZE: begin
                if (mem_ack) begin
                    next_s.w2 = mem_rdata;
                    next_s.buf_valid = 1'b1;
                    next_s.buf_done = 1'b0;
                    next_s.nxt_ok = 1'b0;
                    next_s.st = s.w1[`W1_LAST] ? tx_ring_pkg::S_XMIT : tx_ring_pkg::S_LK_STAT;
                end
            end
            tx_ring_pkg::S_LK_STAT: begin
                if (mem_ack) begin
                    next_s.n1 = mem_rdata;
                    next_s.st = mem_rdata[`W1_OWN] ? tx_ring_pkg::S_LK_ADDR : tx_ring_pkg::S_XMIT;
                end
            end
            tx_ring_pkg::S_LK_ADDR: begin
                if (mem_ack) begin
                    next_s.n0 = mem_rdata;
                    next_s.st = tx_ring_pkg::S_LK_SIZE;
                end
            end
            tx_ring_pkg::S_LK_SIZE: begin
                if (mem_ack) begin
                    next_s.n2 = mem_rdata;
                    next_s.nxt_ok = 1'b1;
                    next_s.st = tx_ring_pkg::S_XMIT;
                end
            end
            tx_ring_pkg::S_XMIT: begin
                if (err_any && !s.buf_err) begin
                    next_s.st = tx_ring_pkg::S_WR_ERR; // error word written only on error
                end else if (s.buf_err) begin
                    if (fifo_empty || tx_complete) begin
                        next_s.st = tx_ring_pkg::S_WR_ERR; // fifo drained after buffer error
                    end
                end else if (tx_complete) begin
                    next_s.st = tx_ring_pkg::S_WR_STAT;
                end else if (s.buf_done && !s.w1[`W1_LAST]) begin
                    if (s.nxt_ok) begin
                        next_s.chain = 1'b1;
                        next_s.st = tx_ring_pkg::S_WR_STAT;
                    end else begin
                        next_s.buf_err = 1'b1;
                        next_s.und_err = 1'b1;
                    end
                end
            end
            tx_ring_pkg::S_WR_ERR: begin
                if (mem_ack) begin
                    next_s.last_err = err_word;
                    next_s.st = tx_ring_pkg::S_WR_STAT;
                end
            end
            tx_ring_pkg::S_WR_STAT: begin
                if (mem_ack) begin
                    next_s.ptr = ptr_next;
                    if (s.chain) begin
                        next_s.chain = 1'b0;
                        next_s.w0 = s.n0;
                        next_s.w1 = s.n1;
                        next_s.w2 = s.n2;
                        next_s.nxt_ok = 1'b0;
                        next_s.buf_done = 1'b0;
                        next_s.buf_valid = 1'b1;
                        next_s.st = s.n1[`W1_LAST] ? tx_ring_pkg::S_XMIT : tx_ring_pkg::S_LK_STAT;
                    end else begin
                        next_s.st = tx_ring_pkg::S_IDLE;
                    end
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.st <= tx_ring_pkg::S_IDLE;
            s.base <= `BASE_RST;
            s.ring_log2 <= `LOG2_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs
    assign reg_rdata = s.rdata;
    assign buf_valid = s.buf_valid;
    assign buf_addr = {s.w1[7:0], s.w0};
    assign buf_len = 12'(12'h000 - s.w2[11:0]);
    assign buf_last = s.w1[`W1_LAST];
    assign tx_abort = s.abort;
    assign rx_accept = rx_desc_owned;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_stat_done;
        (s.st == tx_ring_pkg::S_WR_STAT) && mem_ack;
    endsequence

    sequence seq_unowned_poll;
        (s.st == tx_ring_pkg::S_POLL) && mem_ack && !mem_rdata[`W1_OWN];
    endsequence

    chk_unowned_no_adv: assert property (seq_unowned_poll |=> (s.st == tx_ring_pkg::S_IDLE) && $stable(s.ptr))
        else $error("pointer moved past an unowned descriptor");
    chk_adv_after_clear: assert property (seq_stat_done |=> s.ptr == $past(ptr_next))
        else $error("pointer not advanced after ownership returned");
    chk_ptr_only_after: assert property ($changed(s.ptr) |-> $past(s.st == tx_ring_pkg::S_WR_STAT && mem_ack)
                                         || $past(reg_wr && reg_wdata[`CTRL_INIT]))
        else $error("pointer advanced before ownership cleared");
    chk_own_written_zero: assert property ((s.st == tx_ring_pkg::S_WR_STAT) |-> mem.we && !mem.wdata[`W1_OWN])
        else $error("status write keeps ownership");
    chk_summary_or: assert property ((s.st == tx_ring_pkg::S_WR_STAT)
                                     |-> mem.wdata[`W1_ERR] == (s.late_col | s.car_lost | s.und_err | s.rty_out))
        else $error("error summary differs from flags");
    chk_resv_zero: assert property ((s.st == tx_ring_pkg::S_WR_ERR) |-> !mem.wdata[`W3_RESV])
        else $error("reserved error bit written as one");
    chk_size_untouched: assert property (mem.req && mem.we |-> mem.addr[2:1] != 2'b10)
        else $error("size word written by engine");
    chk_buf_err_under: assert property ($rose(s.buf_err) |-> s.und_err)
        else $error("buffer error without underflow");
    chk_late_abort: assert property (txing && tx_late_collision |=> s.late_col && s.abort ##1 !s.abort)
        else $error("late collision not flagged and aborted");
    chk_retry_limit: assert property (txing && tx_collision && !tx_late_collision && (5'(s.tries + 5'h01) >= limit)
                                      |=> s.rty_out && s.abort)
        else $error("retries not exhausted at limit");
    chk_col_counts: assert property (txing && s.col_run && !tx_attempt_start && !tx_collision && !tx_late_collision
                                     |=> s.col_cnt == 10'($past(s.col_cnt) + 10'h001))
        else $error("collision counter not counting");
    chk_underflow: assert property (txing && fifo_empty && !s.buf_done && !buf_done |=> s.und_err && s.abort)
        else $error("early fifo empty not flagged");

endmodule : tx_desc_ring_engine

// ---- sim/host_mem_model.sv ----
// shared descriptor memory standing in for the host side of the ring
// assumes word accesses through the engine's memory request struct
`timescale 1ns/10ps

module host_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // memory port
    input tx_ring_pkg::mem_req_t mem,
    input wire logic [1:0] stall,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [15:0] words [0:255];
    logic [1:0] cnt;

    // every descriptor starts host owned
    initial foreach (words[i]) words[i] = 16'h0000;

    // answer after stall cycles; read data toggles whenever it is not valid
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h5a5a;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem.req && !mem_ack) begin
                cnt <= cnt + 2'h1;
                if (cnt == stall) begin
                    cnt <= 2'h0;
                    mem_ack <= 1'b1;
                    if (mem.we)
                        words[mem.addr[8:1]] <= mem.wdata;
                    else
                        mem_rdata <= words[mem.addr[8:1]];
                end
            end
        end
    end
endmodule : host_mem_model

// ---- sim/test_transmit_descriptor_ring_engine.sv ----
// self-checking bench for the transmit descriptor ring engine
// assumes the host memory model and the register map header
`timescale 1ns/10ps
`include "tx_ring_regs.svh"

module test_transmit_descriptor_ring_engine;
    logic clk, resetn, reg_wr, reg_rd, tx_attempt_start, tx_sending, rx_desc_owned;
    logic mem_ack, buf_valid, buf_last, tx_abort, rx_accept;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, mem_rdata, base;
    logic [5:0] ev;
    logic [1:0] stall;
    logic [23:0] buf_addr;
    logic [11:0] buf_len;
    tx_ring_pkg::mem_req_t mem;
    int failures, n_tests, tp, nwr;

    // engine and host memory
    tx_desc_ring_engine u_dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .buf_valid(buf_valid), .buf_addr(buf_addr), .buf_len(buf_len), .buf_last(buf_last),
        .buf_done(ev[5]), .tx_attempt_start(tx_attempt_start), .tx_sending(tx_sending),
        .carrier_present(~ev[4]), .tx_collision(ev[0]), .tx_late_collision(ev[1]),
        .fifo_empty(ev[2]), .tx_complete(ev[3]), .tx_abort(tx_abort),
        .rx_desc_owned(rx_desc_owned), .rx_accept(rx_accept)
    );
    host_mem_model u_host (
        .clk(clk), .resetn(resetn), .mem(mem), .stall(stall), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
    );

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // count descriptor writes and buffer hand-offs
    always @(posedge clk) if (buf_valid === 1'b1 || (mem.req && mem.we && mem_ack)) nwr++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(negedge clk);
        check(reg_rdata, 16'h0000);
    endtask : reg_read

    // one-cycle event, then tx_abort looked at in the following cycle
    task automatic pulse(input int i, input logic exp);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        @(negedge clk);
        if (exp !== 1'bx) check(tx_abort, exp);
    endtask : pulse

    // attempt starts g clocks before the next pulse
    task automatic try_gap(input int g);
        @(posedge clk);
        tx_attempt_start <= 1'b1;
        tx_sending <= 1'b1;
        @(posedge clk);
        tx_attempt_start <= 1'b0;
        repeat (g - 2) @(posedge clk);
    endtask : try_gap

    function automatic int widx(input int d);
        return base[8:1] + 4 * (d % 4);
    endfunction : widx

    task automatic put_desc(input int d, input logic own, input logic start_of_packet_flag, input logic end_of_packet_flag,
                            output logic [15:0] w1, output logic [15:0] w3,
                            output logic [23:0] a, output logic [11:0] n);
        a = 24'($urandom);
        n = 12'($urandom_range(1518, 64));
        w1 = {own, 2'b00, 3'($urandom), start_of_packet_flag, end_of_packet_flag, a[23:16]};
        w3 = 16'h2000 | 16'($urandom);
        u_host.words[widx(d)] <= a[15:0];
        u_host.words[widx(d) + 2] <= {4'hf, -n};
        u_host.words[widx(d) + 3] <= w3;
        u_host.words[widx(d) + 1] <= w1; // ownership handed over with the rest
    endtask : put_desc

    task automatic wait_buf(input logic [23:0] a, input logic [11:0] n, input logic last);
        int k;
        k = 0;
        do @(negedge clk); while (buf_valid !== 1'b1 && ++k < 400);
        check(buf_valid, 1'b1);
        check(buf_addr, a);
        check(buf_len, n);
        check(buf_last, last);
    endtask : wait_buf

    // one packet; kind picks clean, an error, or a chain
    task automatic run_pkt(input int kind);
        logic [15:0] w1, w1b, w3, w3b, e, m, st;
        logic [23:0] a, ab;
        logic [11:0] n, nb;
        int g, k;
        @(posedge clk);
        stall <= 2'($urandom);
        rx_desc_owned <= 1'($urandom);
        reg_write(`REG_CTRL, {13'h0000, kind == 3, 2'b01});
        @(posedge clk);
        put_desc(tp, 1'b1, 1'b1, kind < 6, w1, w3, a, n);
        if (kind >= 6) put_desc(tp + 1, kind == 7, kind != 7, 1'b1, w1b, w3b, ab, nb);
        wait_buf(a, n, kind < 6);
        check(rx_accept, rx_desc_owned);
        g = $urandom_range(20, 3);
        try_gap(g);
        case (kind)
            0: pulse(3, 1'b0);
            1: pulse(1, 1'b1);
            2: pulse(4, 1'b1);
            3: pulse(0, 1'b1);
            4: begin
                repeat (15) begin
                    pulse(0, 1'b0);
                    try_gap(g);
                end
                pulse(0, 1'b1);
            end
            5: pulse(2, 1'b1);
            6: begin
                pulse(5, 1'bx);
                pulse(2, 1'bx);
            end
            default: begin
                pulse(5, 1'bx);
                wait_buf(ab, nb, 1'b1);
                check(u_host.words[widx(tp) + 1], w1 & 16'h7fff);
                reg_read(`REG_STATUS, st);
                check(st[15:8], (tp + 1) % 4);
                tp++;
                w1 = w1b;
                w3 = w3b;
                pulse(3, 1'b0);
            end
        endcase
        @(posedge clk);
        tx_sending <= 1'b0;
        k = 0;
        do @(negedge clk); while (u_host.words[widx(tp) + 1][15] !== 1'b0 && ++k < 400);
        e = {kind == 6, kind inside {5, 6}, 1'b0, kind == 1, kind == 2, kind inside {3, 4}, 10'(g)};
        m = e[10] ? 16'hffff : 16'hfc00;
        if (kind == 0 || kind == 7) begin
            check(u_host.words[widx(tp) + 3], w3);
        end else begin
            check(u_host.words[widx(tp) + 3] & m, e & m);
            reg_read(`REG_LAST_ERR, st);
            check(st & m, e & m);
        end
        check(u_host.words[widx(tp) + 1], {1'b0, |{e[14], e[12:10]}, 1'b0, w1[12:0]});
        tp = (tp + 1) % 4;
        repeat (3) @(posedge clk);
        reg_read(`REG_STATUS, st);
        check(st[15:8], tp);
    endtask : run_pkt

    // cut a hang short
    initial begin
        #200000;
        failures++;
        test_done();
    end

    // main sequence
    initial begin
        logic [15:0] v, w1, w3;
        logic [23:0] a;
        logic [11:0] n;
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        ev = 6'h00;
        tx_attempt_start = 1'b0;
        tx_sending = 1'b0;
        rx_desc_owned = 1'b0;
        stall = 2'h0;
        failures = 0;
        n_tests = 0;
        tp = 0;
        void'($urandom(9769));
        base = 16'h0100 + 16'($urandom_range(15, 0)) * 16'h0008;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        reg_read(`REG_STATUS, v);
        check(v[15:8], 8'h00);
        reg_write(8'h14, 16'hffff);
        reg_read(8'h14, v);
        check(v, 16'h0000);
        reg_write(`REG_BASE_LO, base);
        reg_write(`REG_BASE_HI, 16'h0200);
        reg_write(`REG_CTRL, 16'h0003);
        nwr = 0;
        repeat (60) @(posedge clk);
        check(nwr, 0);
        reg_read(`REG_STATUS, v);
        check(v[15:8], 8'h00);
        for (int i = 0; i < 18; i++) run_pkt(i < 8 ? i : $urandom_range(7, 0));
        // stray buffer without a start flag: one status write, no hand-off, clean summary, pointer moves on
        @(posedge clk);
        nwr = 0;
        put_desc(tp, 1'b1, 1'b0, 1'b1, w1, w3, a, n);
        repeat (60) @(posedge clk);
        check(nwr, 1);
        check(u_host.words[widx(tp) + 1], w1 & 16'h7fff);
        check(u_host.words[widx(tp) + 3], w3);
        reg_read(`REG_STATUS, v);
        check(v[15:8], (tp + 1) % 4);
        test_done();
    end
endmodule : test_transmit_descriptor_ring_engine
